// >>> rtl/dot_odt_ctrl.sv
// termination control: mode shadows over apb, odt latencies, dynamic write strength
`timescale 1ns/1ps
// Operation
// - dynamic switching on when write strength nonzero
// - nominal from mr1 bits, write from mr2
// - nominal strength applies outside writes
// - on and off after wl minus two
// - write strength wl minus two after write
// - back to nominal after four/six plus off-latency
// - frozen dll in power-down selects asynchronous timing
// - asynchronous timing skips additive latency
// - asynchronous timing follows sampled odt directly
// - synchronous latency is cwl plus al minus two
// - odt pin cannot switch termination on when termination disabled
module dot_odt_ctrl
	import dot_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ck,
	input  wire logic        odt,
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic        bc_n,
	output logic             rtt_on,
	output logic             rtt_wr_sel,
	output logic      [2:0]  rtt_value
);
	import dot_pkg::*;

	function automatic logic [4:0] cas_lat(input logic [15:0] mr0);
		logic [4:0] code;
		code = {2'b00, mr0[MR0_CL_LSB+2:MR0_CL_LSB]};
		cas_lat = mr0[MR0_CL_LOW] ? 5'(code + CL_BASE_HI) : 5'(code + CL_BASE_LO);
	endfunction : cas_lat

	function automatic logic [4:0] add_lat(input logic [1:0] code, input logic [4:0] cl);
		unique case (code)
			AL_CL1:  add_lat = 5'(cl - 5'h01);
			AL_CL2:  add_lat = 5'(cl - 5'h02);
			default: add_lat = 5'h00;
		endcase
	endfunction : add_lat

	// apb registers
	logic [15:0] mr0_r;
	logic [15:0] mr1_r;
	logic [15:0] mr2_r;
	logic [1:0]  viol_r;
	logic [1:0]  viol_nxt;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;

	wire         setup_ph  = psel & ~penable;
	wire         wr_take   = psel & penable & pready_r & pwrite;
	wire         sel_mr0   = (paddr == MR0_OFF);
	wire         sel_mr1   = (paddr == MR1_OFF);
	wire         sel_mr2   = (paddr == MR2_OFF);
	wire         sel_stat  = (paddr == STATUS_OFF);
	wire         sel_viol  = (paddr == VIOL_OFF);
	wire         addr_hit  = sel_mr0 | sel_mr1 | sel_mr2 | sel_stat | sel_viol;

	// link pin sampling
	logic [PIN_W-1:0] pins_sync;
	logic             ck_rise;

	dot_pin_sync u_sync (
		.pclk       (pclk),
		.presetn    (presetn),
		.pins_async ({1'b0, bc_n, we_n, cas_n, ras_n, cs_n, cke, odt, ck}),
		.pins_sync  (pins_sync),
		.ck_rise    (ck_rise)
	);

	wire         odt_s     = pins_sync[PIN_ODT];
	wire         cke_s     = pins_sync[PIN_CKE];
	wire         wr_cmd    = ck_rise & cke_s & ~pins_sync[PIN_CS_N] & pins_sync[PIN_RAS_N]
	                         & ~pins_sync[PIN_CAS_N] & ~pins_sync[PIN_WE_N];
	wire  [1:0]  bl_mode   = mr0_r[MR0_BL_LSB+1:MR0_BL_LSB];
	wire         burst4    = (bl_mode == BL_FIX4) | ((bl_mode == BL_OTF) & ~pins_sync[PIN_BC_N]);

	// mode decode
	wire  [2:0]  nom_code  = {mr1_r[MR1_NOM_B2], mr1_r[MR1_NOM_B1], mr1_r[MR1_NOM_B0]};
	wire  [1:0]  wr_code   = {mr2_r[MR2_WR_B1], mr2_r[MR2_WR_B0]};
	wire         dyn_en    = |wr_code;
	wire         odt_en    = (|nom_code) | dyn_en;
	wire         async_md  = ~mr0_r[MR0_DLL_PPD] & ~cke_s;
	wire  [4:0]  cl        = cas_lat(mr0_r);
	wire  [4:0]  al        = add_lat(mr1_r[MR1_AL_LSB+1:MR1_AL_LSB], cl);
	wire  [4:0]  cwl       = 5'(CWL_BASE + {2'b00, mr2_r[MR2_CWL_LSB+2:MR2_CWL_LSB]});
	wire  [4:0]  odt_lat   = 5'(cwl + al - ODT_LAT_SUB);
	wire  [4:0]  tap_cwn4  = 5'(odt_lat + CWN4_ADD);
	wire  [4:0]  tap_cwn8  = 5'(odt_lat + CWN8_ADD);

	// history of odt and writes, one entry per link clock edge
	logic [DLY_W-1:0] hist_in;
	logic [DLY_W-1:0] q_lat;
	logic [DLY_W-1:0] q_c4;
	logic [DLY_W-1:0] q_c8;

	assign hist_in[DLY_ODT] = odt_s;
	assign hist_in[DLY_WR8] = wr_cmd & dyn_en & ~burst4;
	assign hist_in[DLY_WR4] = wr_cmd & dyn_en & burst4;

	dot_delay_line u_dly (
		.pclk     (pclk),
		.presetn  (presetn),
		.shift_en (ck_rise),
		.din      (hist_in),
		.tap_a    (odt_lat),
		.tap_b    (tap_cwn4),
		.tap_c    (tap_cwn8),
		.q_a      (q_lat),
		.q_b      (q_c4),
		.q_c      (q_c8)
	);

	// the shift and the tap register each cost a pclk, so act on a strobe two cycles late
	logic        step_d_r;
	logic        step_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_d_r <= 1'b0;
			step_r   <= 1'b0;
		end else begin
			step_d_r <= ck_rise;
			step_r   <= step_d_r;
		end
	end

	wire         wr_start  = step_r & (q_lat[DLY_WR8] | q_lat[DLY_WR4]);
	wire         wr_end    = step_r & (q_c4[DLY_WR4] | q_c8[DLY_WR8]);

	// termination state
	logic        rtt_on_r;
	logic        rtt_on_nxt;
	logic        wr_sel_r;
	logic        wr_sel_nxt;
	logic [2:0]  value_r;
	logic [2:0]  value_nxt;

	// the asynchronous path skips the delay line entirely, so additive latency never enters it
	assign rtt_on_nxt = !odt_en ? 1'b0 :
	                    async_md ? odt_s :
	                    step_r ? q_lat[DLY_ODT] : rtt_on_r;

	// a new write reaching its start wins over an older one reaching its end
	assign wr_sel_nxt = !dyn_en ? 1'b0 :
	                    wr_start ? 1'b1 :
	                    wr_end ? 1'b0 : wr_sel_r;

	assign value_nxt  = wr_sel_nxt ? {1'b0, wr_code} : nom_code;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rtt_on_r <= 1'b0;
			wr_sel_r <= 1'b0;
			value_r  <= 3'h0;
		end else begin
			rtt_on_r <= rtt_on_nxt;
			wr_sel_r <= wr_sel_nxt;
			value_r  <= value_nxt;
		end
	end

	// watch the controller's minimum odt high times and flag a short pulse
	logic        odt_prev_r;
	logic [2:0]  hold_r;
	logic [2:0]  hold_nxt;
	logic        hold_wr_r;
	logic        hold_wr_nxt;

	wire         odt_reg_hi  = ck_rise & odt_s & ~odt_prev_r;
	wire         odt_reg_lo  = ck_rise & ~odt_s & odt_prev_r;
	wire         wr_odt_hi   = wr_cmd & odt_s;
	wire  [2:0]  hold_dec    = (hold_r != 3'h0) ? 3'(hold_r - 3'h1) : 3'h0;
	wire  [2:0]  wr_load     = burst4 ? ODTH4_LOAD : ODTH8_LOAD;
	wire         short_odt   = odt_reg_lo & (hold_r != 3'h0) & ~hold_wr_r;
	wire         short_wr    = odt_reg_lo & (hold_r != 3'h0) & hold_wr_r;

	always_comb begin
		hold_nxt    = hold_r;
		hold_wr_nxt = hold_wr_r;
		if (ck_rise) begin
			hold_nxt = hold_dec;
			if (odt_reg_hi) begin
				hold_nxt    = ODTH4_LOAD;
				hold_wr_nxt = 1'b0;
			end
			if (wr_odt_hi && wr_load >= hold_nxt) begin
				hold_nxt    = wr_load;
				hold_wr_nxt = 1'b1;
			end
			if (!odt_s) begin
				hold_nxt    = 3'h0;
				hold_wr_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			odt_prev_r <= 1'b0;
			hold_r     <= 3'h0;
			hold_wr_r  <= 1'b0;
		end else begin
			hold_r    <= hold_nxt;
			hold_wr_r <= hold_wr_nxt;
			if (ck_rise) begin
				odt_prev_r <= odt_s;
			end
		end
	end

	// write one to clear, but a violation in the same cycle stays set
	wire  [1:0]  viol_clr = (wr_take && sel_viol) ? pwdata[1:0] : 2'b00;
	assign viol_nxt = (viol_r & ~viol_clr) | {short_wr, short_odt};

	// apb slave: zero wait states, read data captured in the setup cycle
	wire  [31:0] status_w = {19'h0, odt_lat, 3'h0, async_md, dyn_en, odt_en, wr_sel_r, rtt_on_r};
	wire  [31:0] rd_mux   = sel_mr0  ? {16'h0, mr0_r} :
	                        sel_mr1  ? {16'h0, mr1_r} :
	                        sel_mr2  ? {16'h0, mr2_r} :
	                        sel_stat ? status_w :
	                        sel_viol ? {30'h0, viol_r} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mr0_r     <= MR0_RST;
			mr1_r     <= MR1_RST;
			mr2_r     <= MR2_RST;
			viol_r    <= 2'b00;
			prdata_r  <= 32'h0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			viol_r    <= viol_nxt;
			pready_r  <= setup_ph;
			pslverr_r <= setup_ph & ~addr_hit;
			if (setup_ph) begin
				prdata_r <= pwrite ? 32'h0 : rd_mux;
			end
			// software must write zero write strength before dll-off operation
			if (wr_take && sel_mr0) begin
				mr0_r <= pwdata[15:0];
			end
			if (wr_take && sel_mr1) begin
				mr1_r <= pwdata[15:0];
			end
			if (wr_take && sel_mr2) begin
				mr2_r <= pwdata[15:0];
			end
		end
	end

	assign prdata     = prdata_r;
	assign pready     = pready_r;
	assign pslverr    = pslverr_r;
	assign rtt_on     = rtt_on_r;
	assign rtt_wr_sel = wr_sel_r;
	assign rtt_value  = value_r;

endmodule : dot_odt_ctrl

// >>> rtl/dot_pkg.sv
// package: register map, mode register fields and latency constants for the termination control
package dot_pkg;

	// register byte offsets on the apb bus
	localparam logic [7:0] MR0_OFF      = 8'h00;
	localparam logic [7:0] MR1_OFF      = 8'h04;
	localparam logic [7:0] MR2_OFF      = 8'h08;
	localparam logic [7:0] STATUS_OFF   = 8'h0C;
	localparam logic [7:0] VIOL_OFF     = 8'h10;

	// reset values of the mode register shadows
	localparam logic [15:0] MR0_RST     = 16'h0000;
	localparam logic [15:0] MR1_RST     = 16'h0000;
	localparam logic [15:0] MR2_RST     = 16'h0000;

	// mode register 0 fields
	localparam int MR0_BL_LSB           = 0;
	localparam int MR0_CL_LOW           = 2;
	localparam int MR0_CL_LSB           = 4;
	localparam int MR0_DLL_PPD          = 12;
	localparam logic [1:0] BL_FIX8      = 2'h0;
	localparam logic [1:0] BL_OTF       = 2'h1;
	localparam logic [1:0] BL_FIX4      = 2'h2;

	// mode register 1 fields
	localparam int MR1_NOM_B0           = 2;
	localparam int MR1_NOM_B1           = 6;
	localparam int MR1_NOM_B2           = 9;
	localparam int MR1_AL_LSB           = 3;
	localparam logic [1:0] AL_ZERO      = 2'h0;
	localparam logic [1:0] AL_CL1       = 2'h1;
	localparam logic [1:0] AL_CL2       = 2'h2;

	// mode register 2 fields
	localparam int MR2_CWL_LSB          = 3;
	localparam int MR2_WR_B0            = 9;
	localparam int MR2_WR_B1            = 10;

	// latency arithmetic, all in link clock cycles
	localparam logic [4:0] CL_BASE_LO   = 5'h04;
	localparam logic [4:0] CL_BASE_HI   = 5'h0C;
	localparam logic [4:0] CWL_BASE     = 5'h05;
	localparam logic [4:0] ODT_LAT_SUB  = 5'h02;
	localparam logic [4:0] CWN4_ADD     = 5'h04;
	localparam logic [4:0] CWN8_ADD     = 5'h06;
	localparam logic [2:0] ODTH4_LOAD   = 3'h3;
	localparam logic [2:0] ODTH8_LOAD   = 3'h5;

	// delay line shape
	localparam int DLY_W                = 3;
	localparam int DLY_D                = 32;
	localparam int DLY_ODT              = 0;
	localparam int DLY_WR8              = 1;
	localparam int DLY_WR4              = 2;

	// link pin vector positions
	localparam int PIN_W                = 9;
	localparam int PIN_CK               = 0;
	localparam int PIN_ODT              = 1;
	localparam int PIN_CKE              = 2;
	localparam int PIN_CS_N             = 3;
	localparam int PIN_RAS_N            = 4;
	localparam int PIN_CAS_N            = 5;
	localparam int PIN_WE_N             = 6;
	localparam int PIN_BC_N             = 7;
	localparam int PIN_SPARE            = 8;

endpackage : dot_pkg

// >>> rtl/dot_pin_sync.sv
// two-flop synchroniser for the link pins with rising edge detect of the link clock
`timescale 1ns/1ps
module dot_pin_sync
	import dot_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [PIN_W-1:0] pins_async,
	output logic      [PIN_W-1:0] pins_sync,
	output logic                  ck_rise
);
	logic [PIN_W-1:0] meta_r;
	logic [PIN_W-1:0] sync_r;
	logic             ck_last_r;
	logic             rise_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r    <= '0;
			sync_r    <= '0;
			ck_last_r <= 1'b0;
			rise_r    <= 1'b0;
		end else begin
			meta_r    <= pins_async;
			sync_r    <= meta_r;
			ck_last_r <= sync_r[PIN_CK];
			rise_r    <= sync_r[PIN_CK] & ~ck_last_r;
		end
	end

	// rise_r lines up with the pin sample held in the stage before, so keep one more copy
	logic [PIN_W-1:0] hold_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_r <= '0;
		end else begin
			hold_r <= sync_r;
		end
	end

	assign pins_sync = hold_r;
	assign ck_rise   = rise_r;

endmodule : dot_pin_sync

// >>> rtl/dot_delay_line.sv
// per-link-cycle history of odt and write events with three registered taps
`timescale 1ns/1ps
module dot_delay_line
	import dot_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             shift_en,
	input  wire logic [DLY_W-1:0] din,
	input  wire logic [4:0]       tap_a,
	input  wire logic [4:0]       tap_b,
	input  wire logic [4:0]       tap_c,
	output logic      [DLY_W-1:0] q_a,
	output logic      [DLY_W-1:0] q_b,
	output logic      [DLY_W-1:0] q_c
);
	logic [DLY_W-1:0] stage_r [DLY_D];
	logic [DLY_W-1:0] qa_r;
	logic [DLY_W-1:0] qb_r;
	logic [DLY_W-1:0] qc_r;

	// stage 0 holds the sample taken at the newest link edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DLY_D; i++) begin
				stage_r[i] <= '0;
			end
		end else if (shift_en) begin
			stage_r[0] <= din;
			for (int i = 1; i < DLY_D; i++) begin
				stage_r[i] <= stage_r[i-1];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			qa_r <= '0;
			qb_r <= '0;
			qc_r <= '0;
		end else begin
			qa_r <= stage_r[tap_a];
			qb_r <= stage_r[tap_b];
			qc_r <= stage_r[tap_c];
		end
	end

	assign q_a = qa_r;
	assign q_b = qb_r;
	assign q_c = qc_r;

endmodule : dot_delay_line

// >>> dv/dot_odt_checker.sv
// checker: port assertions for the termination control, bound to its top
`timescale 1ns/1ps
module dot_odt_checker
	import dot_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        ck,
	input wire logic        odt,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic        bc_n,
	input wire logic        rtt_on,
	input wire logic        rtt_wr_sel,
	input wire logic [2:0]  rtt_value
);
	logic [15:0] mr0_r;
	logic [15:0] mr1_r;
	logic [15:0] mr2_r;
	wire         wr_hit = psel && penable && pready && pwrite;
	wire         en     = |{mr1_r[9], mr1_r[6], mr1_r[2], mr2_r[10:9]};
	wire         dyn    = |mr2_r[10:9];
	wire         asy    = !cke && !mr0_r[MR0_DLL_PPD] && en;
	// shadows follow completed writes, so expectations track software settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mr0_r <= MR0_RST;
			mr1_r <= MR1_RST;
			mr2_r <= MR2_RST;
		end else if (wr_hit) begin
			if (paddr == MR0_OFF) mr0_r <= pwdata[15:0];
			if (paddr == MR1_OFF) mr1_r <= pwdata[15:0];
			if (paddr == MR2_OFF) mr2_r <= pwdata[15:0];
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// cke must sit low a few cycles so the synchronised copy agrees
	sequence s_asy_held;
		asy [*4];
	endsequence
	sequence s_asy_rise;
		s_asy_held ##1 (asy && $rose(odt));
	endsequence
	sequence s_asy_fall;
		s_asy_held ##1 (asy && $fell(odt));
	endsequence
	a_unmapped_err: assert property (psel && !penable && !pwrite && paddr > VIOL_OFF
		|=> pslverr && prdata == 32'h0) else $error("unmapped read accepted");
	a_async_on: assert property (s_asy_rise |-> ##[1:8] rtt_on)
		else $error("async turn-on late");
	a_async_off: assert property (s_asy_fall |-> ##[1:8] !rtt_on)
		else $error("async turn-off late");
	a_sync_not_early: assert property (cke && $rose(odt) |-> (!rtt_on) [*8])
		else $error("sync turn-on early");
	a_term_off: assert property (!en && $past(en) == 1'b0 |-> !rtt_on)
		else $error("termination on while disabled");
	a_nom_value: assert property (!rtt_wr_sel && $stable(mr1_r) |->
		rtt_value == {mr1_r[9], mr1_r[6], mr1_r[2]}) else $error("nominal code wrong");
	a_wr_value: assert property (rtt_wr_sel && $stable(mr2_r) |->
		rtt_value == {1'b0, mr2_r[10:9]}) else $error("write code wrong");
	a_dyn_off: assert property (!dyn && $past(dyn) == 1'b0 |-> !rtt_wr_sel)
		else $error("write strength without dynamic mode");
	a_wrsel_span: assert property ($rose(rtt_wr_sel) |-> rtt_wr_sel [*8])
		else $error("write strength too short");
endmodule : dot_odt_checker

bind dot_odt_ctrl dot_odt_checker dot_odt_checker_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ck, .odt, .cke, .cs_n, .ras_n,
	.cas_n, .we_n, .bc_n, .rtt_on, .rtt_wr_sel, .rtt_value);

// >>> dv/dot_ctrl_model.sv
// controller-side link model: free-running clock, odt and command pins
`timescale 1ns/1ps
module dot_ctrl_model (
	output logic ck,
	output logic odt,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic bc_n
);
	// the memory clock runs free; phase kept off the system clock grid
	initial begin
		ck = 1'b0;
		{odt, cke, cs_n, ras_n, cas_n, we_n, bc_n} = 7'h3F;
		#137;
		forever #200 ck = ~ck;
	end
	// entered at a falling ck edge; pins register at the next rising edge
	task automatic burst(input int hi, input int wr_at, input logic bc4);
		int n;
		n = (hi < 4) ? 4 : hi;
		if (wr_at >= 0 && n < wr_at + (bc4 ? 4 : 6))
			n = wr_at + (bc4 ? 4 : 6);
		for (int i = 0; i <= n; i++) begin
			odt <= (i < n);
			{cs_n, ras_n, cas_n, we_n} <= (i == wr_at) ? 4'h4 : 4'hF;
			bc_n <= (i == wr_at) ? !bc4 : bc4;
			@(negedge ck);
		end
	endtask : burst
	task automatic set_pins(input logic new_cke, input logic new_odt);
		@(negedge ck);
		cke <= new_cke;
		odt <= new_odt;
	endtask : set_pins
endmodule : dot_ctrl_model

// >>> dv/testbench.sv
// testbench: register access, link bursts through the controller model
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin bad_count++; \
	$display("MISMATCH %s exp %0h seen %0h", nm, ex, sn); end end
module testbench;
	import dot_pkg::*;
	typedef struct {logic [15:0] m0, m1, m2; int hi, wr; logic ch; int lat;} dot_row_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        ck, odt, cke, cs_n, ras_n, cas_n, we_n, bc_n, rtt_on, rtt_wr_sel;
	logic [2:0]  rtt_value;
	logic        lon [0:1023];
	logic        lsel [0:1023];
	int          bad_count, compares, ck_n, t0, d, en, dn, nd;
	dot_row_t    rows [9] = '{
		'{16'h0000, 16'h0004, 16'h0200, 7, 0, 1'b0, 3},
		'{16'h0001, 16'h0040, 16'h0400, 6, 1, 1'b1, 3},
		'{16'h0001, 16'h0200, 16'h0600, 6, 0, 1'b0, 3},
		'{16'h0002, 16'h0244, 16'h0400, 4, 0, 1'b1, 3},
		'{16'h0000, 16'h0004, 16'h0000, 6, 0, 1'b0, 3},
		'{16'h0000, 16'h0000, 16'h0600, 6, 0, 1'b0, 3},
		'{16'h0000, 16'h0000, 16'h0000, 5, -1, 1'b0, 3},
		'{16'h0000, 16'h0004, 16'h0208, 8, 2, 1'b0, 4},
		'{16'h0020, 16'h004C, 16'h0200, 6, 0, 1'b0, 8}};
	dot_odt_ctrl dot_odt_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ck, .odt, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bc_n,
		.rtt_on, .rtt_wr_sel, .rtt_value);
	dot_ctrl_model dot_ctrl_model_i (.ck, .odt, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bc_n);
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// what the block shows at each memory clock edge, for latency checks
	always @(posedge ck) begin
		lon[ck_n % 1024] <= rtt_on;
		lsel[ck_n % 1024] <= rtt_wr_sel;
		ck_n <= ck_n + 1;
	end
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int t;
		t = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (t >= 20) bad_count++;
	endtask : apb
	// runs take 9 bursts of about 20 memory clocks; the limit is over ten times that
	initial begin
		#1000000;
		bad_count++;
		print_verdict();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int r = 0; r < 9; r++) begin
			apb(1'b1, MR0_OFF, {16'h0000, rows[r].m0});
			apb(1'b1, MR1_OFF, {16'h0000, rows[r].m1});
			apb(1'b1, MR2_OFF, {16'h0000, rows[r].m2});
			en = |{rows[r].m1[9], rows[r].m1[6], rows[r].m1[2], rows[r].m2[10:9]};
			dn = |rows[r].m2[10:9] && rows[r].wr >= 0;
			nd = rows[r].wr + (rows[r].ch ? 4 : 6);
			@(negedge ck);
			t0 = ck_n;
			dot_ctrl_model_i.burst(rows[r].hi, rows[r].wr, rows[r].ch);
			repeat (rows[r].lat + 8) @(posedge ck);
			for (int k = t0; k < ck_n; k++) begin
				d = k - 1 - rows[r].lat - t0;
				`CHK("rtt_on", en && d >= 0 && d < rows[r].hi, lon[k % 1024])
				`CHK("rtt_wr_sel", dn && d >= rows[r].wr && d < nd, lsel[k % 1024])
			end
			$display("row %0d done", r);
		end
		apb(1'b0, VIOL_OFF, 32'h0);
		`CHK("viol", 32'h00000000, q)
		apb(1'b1, MR1_OFF, 32'hFFFF0004);
		apb(1'b0, MR1_OFF, 32'h0);
		`CHK("mr1", 32'h00000004, q)
		apb(1'b0, 8'h20, 32'h0);
		`CHK("pslverr", 1'b1, e)
		`CHK("prdata", 32'h0, q)
		$display("apb done");
		apb(1'b1, MR0_OFF, 32'h0);
		dot_ctrl_model_i.set_pins(1'b0, 1'b0);
		repeat (6) @(posedge pclk);
		dot_ctrl_model_i.set_pins(1'b0, 1'b1);
		repeat (12) @(posedge pclk);
		`CHK("rtt_on", 1'b1, rtt_on)
		repeat (28) @(posedge pclk);
		dot_ctrl_model_i.set_pins(1'b0, 1'b0);
		repeat (12) @(posedge pclk);
		`CHK("rtt_on", 1'b0, rtt_on)
		// let the stale odt history drain before switching to the latency path
		repeat (40) @(posedge pclk);
		apb(1'b1, MR0_OFF, 32'h00001000);
		dot_ctrl_model_i.set_pins(1'b0, 1'b1);
		repeat (12) @(posedge pclk);
		`CHK("rtt_on", 1'b0, rtt_on)
		repeat (40) @(posedge pclk);
		`CHK("rtt_on", 1'b1, rtt_on)
		dot_ctrl_model_i.set_pins(1'b1, 1'b1);
		$display("async done");
		dot_ctrl_model_i.set_pins(1'b1, 1'b0);
		repeat (40) @(posedge pclk);
		// one link edge of odt high is shorter than the minimum hold
		dot_ctrl_model_i.set_pins(1'b1, 1'b1);
		dot_ctrl_model_i.set_pins(1'b1, 1'b0);
		repeat (12) @(posedge pclk);
		apb(1'b0, VIOL_OFF, 32'h0);
		`CHK("viol", 32'h00000001, q)
		apb(1'b1, VIOL_OFF, 32'h00000001);
		apb(1'b0, VIOL_OFF, 32'h0);
		`CHK("viol", 32'h00000000, q)
		$display("viol done");
		repeat (40) @(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		`CHK("rtt_on", 1'b0, rtt_on)
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, MR1_OFF, 32'h0);
		`CHK("mr1", {16'h0000, MR1_RST}, q)
		apb(1'b0, STATUS_OFF, 32'h0);
		`CHK("status", {19'h0, 5'(CWL_BASE - ODT_LAT_SUB), 8'h00}, q)
		dot_ctrl_model_i.set_pins(1'b1, 1'b1);
		repeat (60) @(posedge pclk);
		`CHK("rtt_on", 1'b0, rtt_on)
		dot_ctrl_model_i.set_pins(1'b1, 1'b0);
		$display("reset done");
		print_verdict();
	end
endmodule : testbench
